/* core/lcms_pkg.sv */
package lcms_pkg;

   // ***************************************************
   // Encodings and reset values
   // ***************************************************
   localparam logic LOOP_SEMI       = 1'b0;
   localparam logic LOOP_FULLY      = 1'b1;
   localparam logic FUNC_FIXED      = 1'b0;
   localparam logic FUNC_SWITCH     = 1'b1;
   localparam logic WIRE_TWO        = 1'b0;
   localparam logic WIRE_FOUR       = 1'b1;
   localparam logic ABS_ON          = 1'b1;
   localparam logic ABS_AVAIL_RST   = 1'b0;

   // Encoder type reported by the connector side
   typedef enum logic [1:0] {
      LCMS_ENC_TWO_WIRE,
      LCMS_ENC_FOUR_WIRE,
      LCMS_ENC_ABZ
   } lcms_enc_t;

   // Control method applied to the position loop
   typedef enum logic [1:0] {
      LCMS_CTRL_SEMI,
      LCMS_CTRL_FULLY
   } lcms_ctrl_t;

   // Drive parameters written by the host
   typedef struct packed {
      logic loop_system_select;
      logic loop_function_select;
      logic abs_position_enable;
      logic load_encoder_wire_method;
      logic droop_clear_on_switch;
   } lcms_param_t;

   // Alarm outputs
   typedef struct packed {
      logic parameter_error_alarm;
      logic encoder_comm_alarm_a;
      logic encoder_comm_alarm_b;
   } lcms_alarm_t;

   localparam lcms_param_t PARAM_RST = '0;
   localparam lcms_alarm_t ALARM_RST = '0;

endpackage

/* core/lcms_top.sv */
`timescale 1ns/1ns
module lcms_top (
   input  wire logic             CLK,
   input  wire logic             RESETN,
   input  wire logic             CE,
   input  wire logic             CYCLE_TICK,
   input  lcms_pkg::lcms_param_t PARAM,
   input  wire logic             CONTROLLER_LOOP_SELECT_CMD,
   input  wire logic             LOOP_SELECT_INPUT,
   input  wire logic             LOOP_INPUT_ASSIGNED,
   input  lcms_pkg::lcms_enc_t   ENC_TYPE,
   input  wire logic             ENC_ABSOLUTE,
   input  wire logic             TWO_AXIS_UNIT,
   output lcms_pkg::lcms_ctrl_t  CTRL_METHOD,
   output logic                  LOAD_SIDE_UNITS,
   output logic                  FOUR_WIRE_SEL,
   output logic                  ABS_AVAILABLE,
   output lcms_pkg::lcms_alarm_t ALARMS
);

   // ***************************************************
   // Combinational method decision
   // ***************************************************
   logic                 in_eff;
   logic                 switching;
   lcms_pkg::lcms_ctrl_t ctrl_d;
   logic                 abs_d;
   logic                 mismatch;
   lcms_pkg::lcms_alarm_t alarm_d;

   assign in_eff    = LOOP_SELECT_INPUT & LOOP_INPUT_ASSIGNED;
   assign switching = (PARAM.loop_system_select == lcms_pkg::LOOP_FULLY) &&
                      (PARAM.loop_function_select == lcms_pkg::FUNC_SWITCH);

   // Method choice; the OR lets either party force fully closed
   always_comb begin
      ctrl_d = lcms_pkg::LCMS_CTRL_SEMI;
      if (PARAM.loop_system_select == lcms_pkg::LOOP_FULLY) begin
         if (switching) begin
            if (CONTROLLER_LOOP_SELECT_CMD | in_eff) begin
               ctrl_d = lcms_pkg::LCMS_CTRL_FULLY;
            end
         end else begin
            ctrl_d = lcms_pkg::LCMS_CTRL_FULLY;
         end
      end
   end

   always_comb begin
      if (PARAM.loop_system_select == lcms_pkg::LOOP_SEMI) begin
         abs_d = 1'b1;
      end else if (switching) begin
         abs_d = 1'b0;
      end else begin
         abs_d = ENC_ABSOLUTE;
      end
   end

   // wire method mismatch; A/B/Z needs two-wire setting
   always_comb begin
      case (ENC_TYPE)
         lcms_pkg::LCMS_ENC_TWO_WIRE:
            mismatch = PARAM.load_encoder_wire_method != lcms_pkg::WIRE_TWO;
         lcms_pkg::LCMS_ENC_FOUR_WIRE:
            mismatch = PARAM.load_encoder_wire_method != lcms_pkg::WIRE_FOUR;
         lcms_pkg::LCMS_ENC_ABZ:
            mismatch = PARAM.load_encoder_wire_method != lcms_pkg::WIRE_TWO;
         default:
            mismatch = 1'b0;
      endcase
   end

   // Alarm levels follow the settings, no latching here
   always_comb begin
      alarm_d.parameter_error_alarm =
         (PARAM.loop_function_select == lcms_pkg::FUNC_SWITCH) &&
         (PARAM.abs_position_enable == lcms_pkg::ABS_ON);
      alarm_d.encoder_comm_alarm_a = mismatch ||
         (TWO_AXIS_UNIT && (ENC_TYPE == lcms_pkg::LCMS_ENC_ABZ));
      alarm_d.encoder_comm_alarm_b = mismatch;
   end

   // ***************************************************
   // Registered outputs
   // ***************************************************

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         CTRL_METHOD     <= lcms_pkg::LCMS_CTRL_SEMI;
         LOAD_SIDE_UNITS <= lcms_pkg::LOOP_SEMI;
      end else if (CE && CYCLE_TICK) begin
         CTRL_METHOD     <= ctrl_d;
         LOAD_SIDE_UNITS <= PARAM.loop_system_select;
      end
   end

   a_load_side_units: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && CYCLE_TICK)
      |=> LOAD_SIDE_UNITS == $past(PARAM.loop_system_select))
      else $error("load-side units not following system select");

   a_switch_or_rule: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && CYCLE_TICK && switching &&
       !CONTROLLER_LOOP_SELECT_CMD && !in_eff)
      |=> CTRL_METHOD == lcms_pkg::LCMS_CTRL_SEMI)
      else $error("switching mode not semi with both off");

   a_fixed_fully_ctrl: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && CYCLE_TICK && PARAM.loop_system_select &&
       !PARAM.loop_function_select)
      |=> CTRL_METHOD == lcms_pkg::LCMS_CTRL_FULLY)
      else $error("fixed mode not fully closed");

   a_semi_system_ctrl: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && CYCLE_TICK && !PARAM.loop_system_select)
      |=> CTRL_METHOD == lcms_pkg::LCMS_CTRL_SEMI && !LOAD_SIDE_UNITS)
      else $error("semi system not semi control");

   a_cmd_forces_fully: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && CYCLE_TICK && switching && CONTROLLER_LOOP_SELECT_CMD)
      |=> CTRL_METHOD == lcms_pkg::LCMS_CTRL_FULLY)
      else $error("command bit did not force fully closed");

   a_unassigned_input: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && CYCLE_TICK && switching && !LOOP_INPUT_ASSIGNED &&
       !CONTROLLER_LOOP_SELECT_CMD)
      |=> CTRL_METHOD == lcms_pkg::LCMS_CTRL_SEMI)
      else $error("unassigned input was not ignored");

   a_hold_off_tick: assert property (
      @(posedge CLK) disable iff (!RESETN)
      !(CE && CYCLE_TICK) |=> $stable(CTRL_METHOD))
      else $error("method changed outside control tick");

   // Settings checks, refreshed every enabled clock
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ALARMS        <= lcms_pkg::ALARM_RST;
         ABS_AVAILABLE <= lcms_pkg::ABS_AVAIL_RST;
         FOUR_WIRE_SEL <= lcms_pkg::WIRE_TWO;
      end else if (CE) begin
         ALARMS        <= alarm_d;
         ABS_AVAILABLE <= abs_d;
         FOUR_WIRE_SEL <= PARAM.load_encoder_wire_method;
      end
   end

   a_param_error: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && PARAM.loop_function_select && PARAM.abs_position_enable)
      |=> ALARMS.parameter_error_alarm)
      else $error("parameter error alarm missing");

   a_abs_switching: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && switching) |=> !ABS_AVAILABLE)
      else $error("absolute detection offered in switching mode");

   a_abs_semi_system: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && !PARAM.loop_system_select) |=> ABS_AVAILABLE)
      else $error("absolute detection missing in semi system");

   a_abs_fixed_enc: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && PARAM.loop_system_select && !PARAM.loop_function_select)
      |=> ABS_AVAILABLE == $past(ENC_ABSOLUTE))
      else $error("fixed mode absolute use not following encoder");

   a_wire_mismatch: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && ENC_TYPE == lcms_pkg::LCMS_ENC_FOUR_WIRE &&
       !PARAM.load_encoder_wire_method)
      |=> ALARMS.encoder_comm_alarm_a && ALARMS.encoder_comm_alarm_b)
      else $error("wire mismatch alarms missing");

   a_two_wire_mismatch: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && ENC_TYPE == lcms_pkg::LCMS_ENC_TWO_WIRE &&
       PARAM.load_encoder_wire_method)
      |=> ALARMS.encoder_comm_alarm_a && ALARMS.encoder_comm_alarm_b)
      else $error("two-wire mismatch alarms missing");

   a_abz_mismatch: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && ENC_TYPE == lcms_pkg::LCMS_ENC_ABZ &&
       PARAM.load_encoder_wire_method)
      |=> ALARMS.encoder_comm_alarm_a && ALARMS.encoder_comm_alarm_b)
      else $error("A/B/Z mismatch alarms missing");

   a_two_axis_abz: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && TWO_AXIS_UNIT && ENC_TYPE == lcms_pkg::LCMS_ENC_ABZ)
      |=> ALARMS.encoder_comm_alarm_a)
      else $error("two-axis A/B/Z alarm missing");

   a_abz_b_clear: assert property (
      @(posedge CLK) disable iff (!RESETN)
      (CE && ENC_TYPE == lcms_pkg::LCMS_ENC_ABZ &&
       !PARAM.load_encoder_wire_method)
      |=> !ALARMS.encoder_comm_alarm_b)
      else $error("alarm b raised for correctly set A/B/Z");

   a_wire_select: assert property (
      @(posedge CLK) disable iff (!RESETN)
      CE |=> FOUR_WIRE_SEL == $past(PARAM.load_encoder_wire_method))
      else $error("wire select not following setting");

endmodule // lcms_top

/* verification/lcms_host_model.sv */
`timescale 1ns/1ns
// Host side: one control-cycle strobe every fourth clock, plus re-homing
module lcms_host_model (
   input  wire logic             CLK,
   input  wire logic             RESETN,
   input  lcms_pkg::lcms_ctrl_t  CTRL,
   input  wire logic             DROOP_CLEAR,
   output logic                  TICK,
   output logic                  REHOME
);
   logic [1:0]           cnt_q;
   lcms_pkg::lcms_ctrl_t ctrl_q;
   logic                 rehome_q;
   // Free count; restarts on reset so strobes never stray
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
      end
   end
   assign TICK = (cnt_q == 2'h3);

   // re-home after a switch
   // Droop clearing on (0) may shift the stop point, so home again
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_q   <= lcms_pkg::LCMS_CTRL_SEMI;
         rehome_q <= 1'b0;
      end else begin
         ctrl_q   <= CTRL;
         rehome_q <= (CTRL != ctrl_q) && (DROOP_CLEAR == 1'b0);
      end
   end
   assign REHOME = rehome_q;
endmodule // lcms_host_model

/* verification/tb_lcms_top.sv */
`timescale 1ns/1ns
module tb_lcms_top;
   // ***************************************************
   // Stimulus and expected state
   // ***************************************************
   logic                  clk = 1'b0;
   logic                  rstn = 1'b0;
   logic                  ce = 1'b0;
   logic                  tick;
   lcms_pkg::lcms_param_t prm = '0;
   logic                  cmd = 1'b0;
   logic                  lin = 1'b0;
   logic                  asg = 1'b0;
   lcms_pkg::lcms_enc_t   enc = lcms_pkg::LCMS_ENC_TWO_WIRE;
   logic                  absn = 1'b0;
   logic                  twox = 1'b0;
   lcms_pkg::lcms_ctrl_t  ctrl;
   logic                  lsu;
   logic                  four;
   logic                  absa;
   lcms_pkg::lcms_alarm_t alm;
   logic                  rehome;
   logic [2:0]            e_m = 3'h0;
   logic [4:0]            e_c = 5'h0;
   logic [31:0]           r;
   integer                seed = 32'hc6bc0e76;
   int                    err_count = 0;
   int                    check_count = 0;
   int                    rehome_count = 0;

   always #5 clk = ~clk;

   lcms_host_model host_u (.CLK(clk), .RESETN(rstn), .CTRL(ctrl),
      .DROOP_CLEAR(prm.droop_clear_on_switch), .TICK(tick),
      .REHOME(rehome));

   always @(posedge clk) begin
      if (rehome) rehome_count++;
   end

   lcms_top dut_u (.CLK(clk), .RESETN(rstn), .CE(ce), .CYCLE_TICK(tick),
      .PARAM(prm), .CONTROLLER_LOOP_SELECT_CMD(cmd),
      .LOOP_SELECT_INPUT(lin), .LOOP_INPUT_ASSIGNED(asg), .ENC_TYPE(enc),
      .ENC_ABSOLUTE(absn), .TWO_AXIS_UNIT(twox), .CTRL_METHOD(ctrl),
      .LOAD_SIDE_UNITS(lsu), .FOUR_WIRE_SEL(four), .ABS_AVAILABLE(absa),
      .ALARMS(alm));

   // Method group: {ctrl, load-side units}
   function automatic logic [2:0] f_meth();
      logic sys;
      logic sw;
      sys = prm.loop_system_select;
      sw = sys & prm.loop_function_select;
      return {1'b0, sys & (!sw | cmd | (lin & asg)), sys};
   endfunction

   // Check group: {four wire, abs usable, alarms}
   function automatic logic [4:0] f_chk();
      logic w;
      logic sw;
      logic mis;
      w = prm.load_encoder_wire_method;
      sw = prm.loop_system_select & prm.loop_function_select;
      mis = (enc == lcms_pkg::LCMS_ENC_FOUR_WIRE) ? !w :
            (enc == lcms_pkg::LCMS_ENC_TWO_WIRE ||
             enc == lcms_pkg::LCMS_ENC_ABZ) ? w : 1'b0;
      return {w, !prm.loop_system_select | (!sw & absn),
              prm.loop_function_select & prm.abs_position_enable,
              mis | (twox & (enc == lcms_pkg::LCMS_ENC_ABZ)), mis};
   endfunction

   task automatic check(input logic [4:0] got, input logic [4:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ***************************************************
   // Tests
   // ***************************************************
   // Corner word: {axis, abs enc, enc type, selects, params, ce}
   function automatic logic [31:0] f_vec(input logic [4:0] p,
                                         input logic [2:0] sel,
                                         input logic [1:0] e,
                                         input logic [1:0] ax);
      return {16'h0, ax, e, sel, p, 4'h1};
   endfunction

   // One clock: compare what the last edge made, then drive anew
   task automatic step(input logic [31:0] v, input logic rn);
      @(posedge clk);
      #1;
      check({2'h0, ctrl, lsu}, {2'h0, e_m});
      check({four, absa, alm}, e_c);
      ce = (v[3:0] != 4'h0);
      prm = v[8:4];
      cmd = v[9];
      lin = v[10];
      asg = v[11];
      enc = lcms_pkg::lcms_enc_t'(v[13:12]);
      absn = v[14];
      twox = v[15];
      rstn = rn;
      if (!rstn) begin
         e_m = 3'h0;
         e_c = 5'h0;
      end else begin
         if (ce) e_c = f_chk();
         if (ce && tick) e_m = f_meth();
      end
   endtask

   // Reset, hand-picked corners, then random traffic with a mid-run reset
   initial begin
      repeat (20) @(posedge clk);
      check({2'h0, ctrl, lsu}, 5'h00);
      check({four, absa, alm}, 5'h00);
      $display("reset test done");
      #1 rstn = 1'b1;
      // Four clocks per corner so a control tick always falls inside
      // fixed fully closed
      repeat (4) step(f_vec(5'h15, 3'h0, 2'h0, 2'h1), 1'b1);
      repeat (4) step(f_vec(5'h19, 3'h2, 2'h0, 2'h0), 1'b1);
      repeat (4) step(f_vec(5'h18, 3'h1, 2'h0, 2'h0), 1'b1);
      repeat (4) step(f_vec(5'h1d, 3'h0, 2'h0, 2'h0), 1'b1);
      repeat (4) step(f_vec(5'h11, 3'h0, 2'h2, 2'h0), 1'b1);
      repeat (4) step(f_vec(5'h11, 3'h0, 2'h2, 2'h2), 1'b1);
      repeat (4) step(f_vec(5'h11, 3'h0, 2'h0, 2'h2), 1'b1);
      repeat (4) step(f_vec(5'h11, 3'h0, 2'h1, 2'h0), 1'b1);
      repeat (4) step(f_vec(5'h00, 3'h7, 2'h3, 2'h3) & 32'hfff0, 1'b1);
      $display("corner test done, rehomes %0d", rehome_count);
      for (int i = 0; i < 600; i++) begin
         r = $random(seed);
         // Mostly running; CE low now and then to prove the freeze
         step(r, !(i inside {300, 301}));
      end
      $display("random test done");
      complete_run();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #20000;
      err_count++;
      complete_run();
   end
endmodule // tb_lcms_top
